// *** testbench/offset_gain_adjust_regs_tb.sv ***
// Self-checking bench for the offset and gain trim bank.
// Assumes the bench drives the write port and mode pin directly.
`timescale 1ns/10ps

module offset_gain_adjust_regs_tb;

	// ------------------------------------------------------------------
	// Signals and bench model
	// ------------------------------------------------------------------
	logic                   clk_i;           // 50 MHz clock
	logic                   rst_i;           // Async reset
	trim_pkg::wr_req_type   wr_i;            // Write request
	logic                   ext_mode_i;      // Mode pin
	trim_pkg::trim_out_type settings_o;      // Applied settings
	logic [8:0]             offset_signed_o; // Signed offset
	logic                   gain_in_range_o; // Band flag
	logic                   ext_active_o;    // Synchronised mode
	int                     n_errors;        // Mismatches
	int                     compares;        // Comparisons
	int                     cycles;          // Timeout counter
	logic [7:0]             s_mag;           // Expected stored magnitude
	logic                   s_neg;           // Expected stored sign
	logic [8:0]             s_gain;          // Expected stored gain
	logic                   s_ext;           // Expected mode
	logic [8:0]             gain_tab [0:4] = '{9'h000, 9'h0c0, 9'h1c0, 9'h1c1, 9'h1ff};
	logic [7:0]             mag_tab  [0:2] = '{8'h00, 8'h01, 8'hff};

	offset_gain_adjust_regs u_dut
	(
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.wr_i            (wr_i),
		.ext_mode_i      (ext_mode_i),
		.settings_o      (settings_o),
		.offset_signed_o (offset_signed_o),
		.gain_in_range_o (gain_in_range_o),
		.ext_active_o    (ext_active_o)
	);

	// Free-running clock
	initial clk_i = 1'b0;
	always #10 clk_i = ~clk_i;

	// Hang guard, far above the roughly 85 cycles the run needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic print_verdict;
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		compares++;
		if (exp !== got)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Expected outputs from the bench model; normal mode applies no trim
	task automatic expect_all;
		trim_pkg::trim_out_type e;
		logic [8:0]             sg;
		e = {8'h00, 1'b0, 9'h100};
		if (s_ext === 1'b1)
			e = {s_mag, s_neg, s_gain};
		sg = e.offset_neg ? 9'h000 - {1'b0, e.offset_mag} : {1'b0, e.offset_mag};
		chk("settings", 18'(e), 18'(settings_o));
		chk("offset_signed", 18'(sg), 18'(offset_signed_o));
		chk("gain_in_range", 18'(s_gain >= 9'h0c0 && s_gain <= 9'h1c0), 18'(gain_in_range_o));
		chk("ext_active", 18'(s_ext), 18'(ext_active_o));
	endtask : expect_all

	// One write cycle; strobe left high so calls run back to back
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= '{en: 1'b1, addr: a, data: d};
		if (a == 4'h2)
		begin
			s_mag = d[15:8];
			s_neg = d[7];
		end
		else if (a == 4'h3)
			s_gain = d[15:7];
	endtask : wr

	// Drop the strobe, then let the write reach the outputs
	task automatic idle_settle;
		@(posedge clk_i);
		wr_i.en <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : idle_settle

	task automatic set_mode(input logic m);
		@(posedge clk_i);
		ext_mode_i <= m;
		s_ext = m;
		repeat (4) @(posedge clk_i);
		#1;
	endtask : set_mode

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		n_errors = 0;
		compares = 0;
		cycles = 0;
		rst_i = 1'b1;
		wr_i = '0;
		ext_mode_i = 1'b0;
		{s_mag, s_neg, s_gain, s_ext} = {8'h00, 1'b0, 9'h100, 1'b0};
		repeat (3) @(posedge clk_i);
		#1;
		expect_all();
		@(posedge clk_i);
		rst_i <= 1'b0;
		// Writes in normal mode are kept but not applied
		wr(4'h2, 16'hab7f);
		wr(4'h3, 16'hffff);
		idle_settle();
		expect_all();
		set_mode(1'b1);
		expect_all();
		// Gain codes at and beyond the band edges
		for (int i = 0; i < 5; i++)
		begin
			wr(4'h3, {gain_tab[i], 7'h7f});
			idle_settle();
			expect_all();
		end
		// Offset magnitudes with both signs, negative zero included
		for (int j = 0; j < 6; j++)
		begin
			wr(4'h2, {mag_tab[j / 2], 1'(j % 2), 7'h7f});
			idle_settle();
			expect_all();
		end
		// Unmapped addresses back to back leave both registers alone
		wr(4'h0, 16'h0000);
		wr(4'h1, 16'h0000);
		wr(4'h4, 16'h0000);
		wr(4'hf, 16'h0000);
		idle_settle();
		expect_all();
		// Back-to-back writes, last one to each address wins
		wr(4'h2, 16'h12ff);
		wr(4'h3, 16'h607f);
		wr(4'h2, 16'h3c7f);
		idle_settle();
		expect_all();
		set_mode(1'b0);
		expect_all();
		// Reset in mid-run restores defaults
		@(posedge clk_i);
		rst_i <= 1'b1;
		{s_mag, s_neg, s_gain} = {8'h00, 1'b0, 9'h100};
		repeat (2) @(posedge clk_i);
		#1;
		expect_all();
		@(posedge clk_i);
		rst_i <= 1'b0;
		set_mode(1'b1);
		expect_all();
		print_verdict();
	end

endmodule : offset_gain_adjust_regs_tb

// *** verilog/offset_gain_adjust_regs.sv ***
// Offset and full-scale trim bank of the converter's extended control set.
// Assumes writes arrive already deserialised as one-cycle strobes on clk_i,
// and the extended-mode selection arrives from a pin, so it is synchronised.
`timescale 1ns/10ps

module offset_gain_adjust_regs
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire trim_pkg::wr_req_type  wr_i,            // Register write request
	input  wire logic                  ext_mode_i,      // Extended control mode pin
	output trim_pkg::trim_out_type     settings_o,      // Settings to converter core
	output logic [8:0]                 offset_signed_o, // Offset in steps, signed
	output logic                       gain_in_range_o, // Stored gain inside band
	output logic                       ext_active_o     // Synchronised mode
);

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	logic       offset_load;                       // Write hits offset trim
	logic       gain_load;                         // Write hits full-scale trim
	logic [8:0] offset_field;                      // Stored magnitude and sign
	logic [8:0] gain_field;                        // Stored gain code

	// Decode both addresses; filler bits are not stored, so a writer
	// that forgets them cannot disturb the fields
	assign offset_load = wr_i.en && (wr_i.addr == trim_pkg::OFFSET_TRIM_ADDR);
	assign gain_load   = wr_i.en && (wr_i.addr == trim_pkg::FULL_SCALE_TRIM_ADDR);
	// Other addresses fall through untouched, so the rest of the
	// extended set can share this write port without any effect here

	// ------------------------------------------------------------------
	// Stored fields
	// ------------------------------------------------------------------
	// Offset word bits 15:7 hold magnitude and sign
	trim_field_reg
	#(
		.W           (9),
		.RESET_VALUE (trim_pkg::OFFSET_FIELD_RESET)
	)
	offset_store
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (offset_load),
		.data_i (wr_i.data[trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB]),
		.q_o    (offset_field)
	);

	// Full-scale word bits 15:7 hold the gain code
	trim_field_reg
	#(
		.W           (9),
		.RESET_VALUE (trim_pkg::GAIN_FIELD_RESET)
	)
	gain_store
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (gain_load),
		.data_i (wr_i.data[trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB]),
		.q_o    (gain_field)
	);

	// ------------------------------------------------------------------
	// Bank state
	// ------------------------------------------------------------------
	trim_pkg::bank_state_type s_q;                 // Registered state
	trim_pkg::bank_state_type s_d;                 // Next state

	// Next state: sync the mode pin, then choose applied settings
	always_comb
	begin
		s_d           = s_q;
		s_d.mode_meta = ext_mode_i;
		s_d.mode_sync = s_q.mode_meta;
		if (s_q.mode_sync)
		begin
			// Extended mode: fields go straight to the core
			s_d.out.offset_mag = offset_field[trim_pkg::OFFSET_MAG_MSB:trim_pkg::OFFSET_MAG_LSB];
			s_d.out.offset_neg = offset_field[trim_pkg::OFFSET_SIGN_POS];
			s_d.out.gain_code  = gain_field;
		end
		else
		begin
			// Normal mode: stored values kept but not applied
			// Keeping them costs nothing and applies the last write on switch
			s_d.out.offset_mag = trim_pkg::OFFSET_MAG_ZERO;
			s_d.out.offset_neg = 1'b0;
			s_d.out.gain_code  = trim_pkg::GAIN_NOMINAL;
		end
		// Signed step count; one code is one fixed step either way
		if (s_d.out.offset_neg)
		begin
			s_d.offset_signed = 9'(-{1'b0, s_d.out.offset_mag});
		end
		else
		begin
			s_d.offset_signed = {1'b0, s_d.out.offset_mag};
		end
		// Advisory only; out-of-band codes are still applied
		s_d.gain_in_range = (gain_field >= trim_pkg::GAIN_REC_MIN) &&
		                    (gain_field <= trim_pkg::GAIN_REC_MAX);
	end

	// Register the whole state
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_q <= trim_pkg::BANK_STATE_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------------
	// Core sees only registered values, so no decode glitch reaches it
	assign settings_o      = s_q.out;
	assign offset_signed_o = s_q.offset_signed;
	assign gain_in_range_o = s_q.gain_in_range;
	assign ext_active_o    = s_q.mode_sync;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// One clock domain, so clocking and reset are declared once
	// Reset disables every check; reset checks look one edge after release
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A decoded offset write lands in its field one edge later
	offset_write_a: assert property (
		offset_load |=> offset_field == $past(wr_i.data[15:7]))
		else $error("offset write not stored");

	// Same landing for the full-scale word
	gain_write_a: assert property (
		gain_load |=> gain_field == $past(wr_i.data[15:7]))
		else $error("gain write not stored");

	// Every stored code inside the band raises the flag
	band_inside_a: assert property (
		((gain_field >= 9'h0c0) && (gain_field <= 9'h1c0)) |=> gain_in_range_o)
		else $error("in-band gain not flagged");

	// Codes outside the band clear it; such codes are still applied
	band_outside_a: assert property (
		((gain_field < 9'h0c0) || (gain_field > 9'h1c0)) |=> !gain_in_range_o)
		else $error("out-of-band gain flagged");

	// Flag outputs that reset alone fixes, seen just after release
	reset_outputs_a: assert property (
		$past(rst_i) |-> (offset_signed_o == 9'h000) && gain_in_range_o && !ext_active_o)
		else $error("flag outputs wrong after reset");

	// Mode pin reaches the flag two edges later; the edges right after
	// release are skipped because the synchroniser was held in reset
	mode_sync_a: assert property (
		!$past(rst_i) && !$past(rst_i, 2) |-> ext_active_o == $past(ext_mode_i, 2))
		else $error("mode pin not synchronised in two edges");

	// Zero magnitude adds no steps, whatever the sign says
	neg_zero_a: assert property (
		(settings_o.offset_mag == 8'h00) |-> (offset_signed_o == 9'h000))
		else $error("zero magnitude gives nonzero steps");

	// A positive setting reports its magnitude unchanged
	offset_pos_a: assert property (
		!settings_o.offset_neg |-> (offset_signed_o == {1'b0, settings_o.offset_mag}))
		else $error("positive offset steps wrong");

	offset_mag_apply_a: assert property (
		s_q.mode_sync |=> settings_o.offset_mag == $past(offset_field[8:1]))
		else $error("offset magnitude not applied");

	offset_step_a: assert property (
		offset_signed_o == (settings_o.offset_neg ? 9'(-{1'b0, settings_o.offset_mag})
		                                          : {1'b0, settings_o.offset_mag}))
		else $error("signed offset steps wrong");

	offset_sign_a: assert property (
		s_q.mode_sync |=> settings_o.offset_neg == $past(offset_field[0]))
		else $error("offset sign not applied");

	offset_reset_a: assert property (
		$past(rst_i) |-> (offset_field == 9'h000) && (settings_o.offset_mag == 8'h00)
		                 && !settings_o.offset_neg)
		else $error("offset not zero after reset");

	gain_reset_a: assert property (
		$past(rst_i) |-> (gain_field == 9'h100) && (settings_o.gain_code == 9'h100))
		else $error("gain not nominal after reset");

	gain_direct_a: assert property (
		(gain_load && s_q.mode_sync) ##1 s_q.mode_sync
		|=> settings_o.gain_code == $past(wr_i.data[15:7], 2))
		else $error("written gain not applied in two cycles");

	normal_mode_a: assert property (
		!s_q.mode_sync |=> (settings_o.offset_mag == 8'h00) && !settings_o.offset_neg
		                   && (settings_o.gain_code == 9'h100))
		else $error("trim applied in normal mode");

	offset_hold_a: assert property (
		!offset_load |=> $stable(offset_field))
		else $error("offset field changed without write");

	gain_hold_a: assert property (
		!gain_load |=> $stable(gain_field))
		else $error("gain field changed without write");

	gain_band_a: assert property (
		(gain_field == 9'h1c1) |=> !gain_in_range_o)
		else $error("gain band flag wrong");

endmodule : offset_gain_adjust_regs

// *** verilog/trim_field_reg.sv ***
// One write-only trim field with its own reset value.
// Assumes the load strobe and data come from logic on the same clock.
`timescale 1ns/10ps

module trim_field_reg
#(
	parameter int             W           = 9,
	parameter logic [W-1:0]   RESET_VALUE = '0
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,      // Write to this register
	input  wire logic [W-1:0] data_i,      // Field bits of the written word
	output logic      [W-1:0] q_o          // Held field
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [W-1:0] field_q;                 // Held value
	logic [W-1:0] field_d;                 // Next value

	// Load on write, else keep; no other path alters it
	always_comb
	begin
		field_d = field_q;
		if (load_i)
		begin
			field_d = data_i;
		end
	end

	// Reset to the power-on value
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			field_q <= RESET_VALUE;
		end
		else
		begin
			field_q <= field_d;
		end
	end

	assign q_o = field_q;

endmodule : trim_field_reg

// *** verilog/trim_pkg.sv ***
// Constants, field layouts and carrier types for the offset and gain trim bank.
// Assumes one 50 MHz register clock and a parallel write port on that clock.
//
// Operation
// - Offset bits 15:8 are unsigned linear magnitude.
// - Each magnitude code adds one constant offset step.
// - Bit 7 selects offset polarity, one negative.
// - Reset leaves offset magnitude and sign zero.
// - Full-scale bits 15:7 form linear gain code.
// - Reset gain code is one then eight zeros.
// - New gain code applies without any recalibration.
// - Trims apply only in extended control mode.
package trim_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [3:0]  OFFSET_TRIM_ADDR     = 4'h2;     // Offset trim register
	localparam logic [3:0]  FULL_SCALE_TRIM_ADDR = 4'h3;     // Full-scale trim register

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int          FIELD_MSB            = 15;       // Top of both stored fields
	localparam int          FIELD_LSB            = 7;        // Bottom of both stored fields
	localparam int          OFFSET_MAG_MSB       = 8;        // Magnitude within stored field
	localparam int          OFFSET_MAG_LSB       = 1;
	localparam int          OFFSET_SIGN_POS      = 0;        // Sign within stored field
	localparam int          FILL_MSB             = 6;        // Must-be-one filler bits

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] OFFSET_TRIM_RESET    = 16'h007f; // No offset applied
	localparam logic [15:0] FULL_SCALE_TRIM_RESET = 16'h807f; // Nominal range
	localparam logic [8:0]  OFFSET_FIELD_RESET   = OFFSET_TRIM_RESET[FIELD_MSB:FIELD_LSB];
	localparam logic [8:0]  GAIN_FIELD_RESET     = FULL_SCALE_TRIM_RESET[FIELD_MSB:FIELD_LSB];
	localparam logic [7:0]  OFFSET_MAG_ZERO      = 8'h00;    // Zero offset magnitude
	localparam logic [8:0]  GAIN_NOMINAL         = 9'h100;   // Nominal gain code

	// ------------------------------------------------------------------
	// Recommended gain band and offset scaling
	// ------------------------------------------------------------------
	localparam logic [8:0]  GAIN_REC_MIN         = 9'h0c0;   // Lower recommended code
	localparam logic [8:0]  GAIN_REC_MAX         = 9'h1c0;   // Upper recommended code
	localparam int          OFFSET_STEP_UV       = 176;      // Offset per code, microvolts
	localparam int          OFFSET_FULL_MV       = 45;       // Offset at all-ones code

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        en;                                  // One-cycle write strobe
		logic [3:0]  addr;                                // Register address
		logic [15:0] data;                                // Full register word
	} wr_req_type;

	typedef struct packed {
		logic [7:0]  offset_mag;                          // Applied offset magnitude
		logic        offset_neg;                          // Applied polarity, one negative
		logic [8:0]  gain_code;                           // Applied full-scale code
	} trim_out_type;

	typedef struct packed {
		logic         mode_meta;                          // Mode pin, first stage
		logic         mode_sync;                          // Mode pin, second stage
		trim_out_type out;                                // Applied settings
		logic [8:0]   offset_signed;                      // Offset in steps, two's complement
		logic         gain_in_range;                      // Stored gain within band
	} bank_state_type;

	localparam bank_state_type BANK_STATE_RESET = '{
		mode_meta:     1'b0,
		mode_sync:     1'b0,
		out:           '{offset_mag: OFFSET_MAG_ZERO, offset_neg: 1'b0,
		                 gain_code: GAIN_NOMINAL},
		offset_signed: 9'h000,
		gain_in_range: 1'b1
	};

endpackage : trim_pkg
